// ===== design/scd_map.vh
// Behaviour
// [R1] Clock configuration registers accept writes only while the unlock bit (bit 0 of the write-protect register) is 1.
// [R2] The low-speed on-chip oscillator runs while bit 1 of the oscillator control register is 0.
// [R3] When both external clock pin function bits are 1, the pins become crystal input and output and oscillation is on.
// [R4] Software waits for the crystal to stabilise before selecting it as the high-speed clock.
// [R5] Bit 6 of the system clock control register at 0 selects the crystal clock as the high-speed clock.
// [R6] The system clock is the base clock divided by the 8-bit divider value plus one.
// [R7] Bit 7 of the base clock stop control register at 1 selects the high-speed clock as the system base clock.
// [R8] A CPU division field of all zeros gives a CPU clock equal to the system clock.
// [R9] Bit 1 of the module standby register at 0 keeps the timer active and clocked.
// [R10] Software unlocks, starts the low-speed oscillator, enables the crystal, waits, selects clocks and dividers, then relocks.
// [R11] Writes to protected registers while locked are ignored and leave the contents unchanged.
`ifndef SCD_MAP_VH
`define SCD_MAP_VH
`define SCD_OFS_PROTECT 8'h00
`define SCD_OFS_OSC_CTRL 8'h04
`define SCD_OFS_EXT_CTRL 8'h08
`define SCD_OFS_SYS_CTRL 8'h0C
`define SCD_OFS_SYS_DIV 8'h10
`define SCD_OFS_BASE_CTRL 8'h14
`define SCD_OFS_STANDBY 8'h18
`define SCD_OFS_STATUS 8'h1C
`define SCD_RST_PROTECT 8'h00
`define SCD_RST_OSC_CTRL 8'h00
`define SCD_RST_EXT_CTRL 8'h00
`define SCD_RST_SYS_CTRL 8'h40
`define SCD_RST_SYS_DIV 8'h00
`define SCD_RST_BASE_CTRL 8'h00
`define SCD_RST_STANDBY 8'h02
`define SCD_BIT_UNLOCK 0
`define SCD_BIT_LOW_OSC_STOP 1
`define SCD_BIT_PIN_LO 0
`define SCD_BIT_PIN_HI 1
`define SCD_BIT_HS_SEL 6
`define SCD_BIT_BASE_SEL 7
`define SCD_BIT_TIMER_STBY 1
`define SCD_CPU_DIV_MSB 2
`define SCD_CPU_DIV_LSB 0
`define SCD_ADDR_LSB 2
`define SCD_ADDR_MSB 7
`define SCD_HTRANS_NONSEQ 2'h2
`endif

// ===== design/scd_divider.v
`timescale 1ns/1ps
// Programmable enable divider: pulse once every (ratio+1) input enables
module scd_divider #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire in_en,
  input wire [WIDTH-1:0] ratio,
  output reg out_en
);
  reg [WIDTH-1:0] count;

  // Ratio zero passes every input enable; a shorter ratio takes effect at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= {WIDTH{1'b0}};
      out_en <= 1'b0;
    end else begin
      out_en <= 1'b0;
      if (in_en) begin
        if (count >= ratio) begin
          count <= {WIDTH{1'b0}};
          out_en <= 1'b1; // [R6]
        end else begin
          count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // scd_divider

// ===== design/scd_clock_ctrl.v
`timescale 1ns/1ps
`include "scd_map.vh"
// Clock source selection, dividers and write protection, AHB-Lite slave
module scd_clock_ctrl (
  input wire CORE_CLK,
  input wire RST_B,
  input wire HSEL,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [2:0] HSIZE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  input wire HS_OSC_TICK,
  input wire XTAL_TICK,
  output reg LOW_OSC_RUN,
  output reg XTAL_OSC_EN,
  output reg CRYSTAL_INPUT_SEL,
  output reg CRYSTAL_OUTPUT_SEL,
  output reg SYS_CLK_EN,
  output reg CPU_CLK_EN,
  output reg TIMER_CLK_EN,
  output reg TIMER_ACTIVE
);
  reg rst_meta;
  reg rst_n;
  wire [1:0] osc_tick;
  wire [1:0] osc_rise;
  reg [7:0] protect;
  reg [7:0] osc_ctrl;
  reg [7:0] ext_ctrl;
  reg [7:0] sys_ctrl;
  reg [7:0] sys_div;
  reg [7:0] base_ctrl;
  reg [7:0] standby;
  reg wr_pend;
  reg [5:0] wr_idx;
  reg [2:0] cpu_count;
  wire clock_reg_write_unlock;
  wire high_speed_clock;
  wire system_base_clock;
  wire sys_tick;
  wire cpu_tick;
  wire [2:0] cpu_div;
  wire [7:0] status;
  reg [31:0] next_rdata;
  reg [7:0] next_protect;
  reg [7:0] next_osc_ctrl;
  reg [7:0] next_ext_ctrl;
  reg [7:0] next_sys_ctrl;
  reg [7:0] next_sys_div;
  reg [7:0] next_base_ctrl;
  reg [7:0] next_standby;
  wire [7:0] wr_addr;
  wire addr_ok;

  // Reset release through two flops; assertion stays asynchronous
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Oscillator levels come from other domains: two flops, then two more of edge history
  assign osc_tick = {XTAL_TICK, HS_OSC_TICK};
  genvar src;
  generate
    for (src = 0; src < 2; src = src + 1) begin : g_tick_sync
      reg [3:0] stage;
      always @(posedge CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
          stage <= 4'h0;
        end else begin
          stage <= {stage[2:0], osc_tick[src]};
        end
      end
      // First stage feeds nothing but the second, so metastability stays contained
      assign osc_rise[src] = stage[2] & ~stage[3];
    end
  endgenerate

  assign clock_reg_write_unlock = protect[`SCD_BIT_UNLOCK];
  assign wr_addr = {wr_idx, 2'h0};
  // Crystal edges only count once its pins are in crystal mode
  assign high_speed_clock = sys_ctrl[`SCD_BIT_HS_SEL] ? osc_rise[0] :
    (osc_rise[1] & XTAL_OSC_EN); // [R5]
  // Low-speed path is not modelled here; base select 0 holds the system clock
  assign system_base_clock = base_ctrl[`SCD_BIT_BASE_SEL] & high_speed_clock; // [R7]
  assign cpu_div = sys_ctrl[`SCD_CPU_DIV_MSB:`SCD_CPU_DIV_LSB];
  assign addr_ok = (HADDR[1:0] == 2'b00) && (HADDR[7:5] == 3'b000);
  assign status = {5'h00, XTAL_OSC_EN, LOW_OSC_RUN, clock_reg_write_unlock};

  scd_divider #(
    .WIDTH(8)
  ) u_sys_div (
    .clk(CORE_CLK),
    .rst_n(rst_n),
    .in_en(system_base_clock),
    .ratio(sys_div),
    .out_en(sys_tick)
  );

  // CPU clock divides the system clock by 2^field, by 8 for any field of 3 or more; zero passes it through
  assign cpu_tick = sys_tick && (((cpu_count + 3'h1) & ((3'h1 << cpu_div) - 3'h1)) == 3'h0 ||
    cpu_div == 3'h0); // [R8]

  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cpu_count <= 3'h0;
    end else if (sys_tick) begin
      cpu_count <= cpu_count + 3'h1;
    end
  end

  // Bus address phase capture; one wait-free data phase per write
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      wr_pend <= 1'b0;
      wr_idx <= 6'h00;
    end else if (HREADY) begin
      wr_pend <= HSEL && HWRITE && (HTRANS == `SCD_HTRANS_NONSEQ) && addr_ok;
      wr_idx <= HADDR[`SCD_ADDR_MSB:`SCD_ADDR_LSB];
    end
  end

  // Next register values; the protect register itself is always writable
  always @* begin
    next_protect = protect;
    next_osc_ctrl = osc_ctrl;
    next_ext_ctrl = ext_ctrl;
    next_sys_ctrl = sys_ctrl;
    next_sys_div = sys_div;
    next_base_ctrl = base_ctrl;
    next_standby = standby;
    if (wr_pend) begin
      if (wr_addr == `SCD_OFS_PROTECT) begin
        next_protect = HWDATA[7:0]; // [R1]
      end
      if (clock_reg_write_unlock) begin // [R1] [R11]
        case (wr_addr)
          `SCD_OFS_OSC_CTRL: next_osc_ctrl = HWDATA[7:0];
          `SCD_OFS_EXT_CTRL: next_ext_ctrl = HWDATA[7:0];
          `SCD_OFS_SYS_CTRL: next_sys_ctrl = HWDATA[7:0];
          `SCD_OFS_SYS_DIV: next_sys_div = HWDATA[7:0];
          `SCD_OFS_BASE_CTRL: next_base_ctrl = HWDATA[7:0];
          default: ;
        endcase
      end
      // Module standby is not behind the protect gate
      if (wr_addr == `SCD_OFS_STANDBY) begin
        next_standby = HWDATA[7:0];
      end
    end
  end

  // Register update from the next values
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      protect <= `SCD_RST_PROTECT;
      osc_ctrl <= `SCD_RST_OSC_CTRL;
      ext_ctrl <= `SCD_RST_EXT_CTRL;
      sys_ctrl <= `SCD_RST_SYS_CTRL;
      sys_div <= `SCD_RST_SYS_DIV;
      base_ctrl <= `SCD_RST_BASE_CTRL;
      standby <= `SCD_RST_STANDBY;
    end else begin
      protect <= next_protect;
      osc_ctrl <= next_osc_ctrl;
      ext_ctrl <= next_ext_ctrl;
      sys_ctrl <= next_sys_ctrl;
      sys_div <= next_sys_div;
      base_ctrl <= next_base_ctrl;
      standby <= next_standby;
    end
  end

  // Read mux on next values, so a read right behind a write to the same word sees the new data
  always @* begin
    next_rdata = 32'h00000000;
    case (HADDR)
      `SCD_OFS_PROTECT: next_rdata = {24'h000000, next_protect};
      `SCD_OFS_OSC_CTRL: next_rdata = {24'h000000, next_osc_ctrl};
      `SCD_OFS_EXT_CTRL: next_rdata = {24'h000000, next_ext_ctrl};
      `SCD_OFS_SYS_CTRL: next_rdata = {24'h000000, next_sys_ctrl};
      `SCD_OFS_SYS_DIV: next_rdata = {24'h000000, next_sys_div};
      `SCD_OFS_BASE_CTRL: next_rdata = {24'h000000, next_base_ctrl};
      `SCD_OFS_STANDBY: next_rdata = {24'h000000, next_standby};
      `SCD_OFS_STATUS: next_rdata = {24'h000000, status};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data registered at the address phase, ready in the data phase
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      HRDATA <= 32'h00000000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      if (HREADY && HSEL && !HWRITE && HTRANS == `SCD_HTRANS_NONSEQ) begin
        HRDATA <= next_rdata;
      end
    end
  end

  // Clock enables and pin controls, all registered
  always @(posedge CORE_CLK or negedge rst_n) begin
    if (!rst_n) begin
      LOW_OSC_RUN <= 1'b0;
      XTAL_OSC_EN <= 1'b0;
      CRYSTAL_INPUT_SEL <= 1'b0;
      CRYSTAL_OUTPUT_SEL <= 1'b0;
      SYS_CLK_EN <= 1'b0;
      CPU_CLK_EN <= 1'b0;
      TIMER_CLK_EN <= 1'b0;
      TIMER_ACTIVE <= 1'b0;
    end else begin
      LOW_OSC_RUN <= ~osc_ctrl[`SCD_BIT_LOW_OSC_STOP]; // [R2]
      XTAL_OSC_EN <= ext_ctrl[`SCD_BIT_PIN_LO] & ext_ctrl[`SCD_BIT_PIN_HI]; // [R3]
      CRYSTAL_INPUT_SEL <= ext_ctrl[`SCD_BIT_PIN_LO] & ext_ctrl[`SCD_BIT_PIN_HI]; // [R3]
      CRYSTAL_OUTPUT_SEL <= ext_ctrl[`SCD_BIT_PIN_LO] & ext_ctrl[`SCD_BIT_PIN_HI]; // [R3]
      SYS_CLK_EN <= sys_tick; // [R6]
      CPU_CLK_EN <= cpu_tick; // [R8]
      TIMER_CLK_EN <= sys_tick & ~standby[`SCD_BIT_TIMER_STBY]; // [R9]
      TIMER_ACTIVE <= ~standby[`SCD_BIT_TIMER_STBY]; // [R9]
    end
  end
endmodule // scd_clock_ctrl

// ===== testbench/scd_clock_ctrl_checker.sv
`timescale 1ns/1ps
module scd_clock_ctrl_checker (
  input wire CORE_CLK,
  input wire RST_B,
  input wire HSEL,
  input wire HWRITE,
  input wire HREADYOUT,
  input wire HRESP,
  input wire [7:0] HADDR,
  input wire [1:0] HTRANS,
  input wire [31:0] HWDATA,
  input wire LOW_OSC_RUN,
  input wire XTAL_OSC_EN,
  input wire CRYSTAL_INPUT_SEL,
  input wire CRYSTAL_OUTPUT_SEL,
  input wire SYS_CLK_EN,
  input wire CPU_CLK_EN,
  input wire TIMER_CLK_EN,
  input wire TIMER_ACTIVE
);
  reg wp, lk;
  reg [7:0] wa, wd;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_B);
  // Shadow of write data phases and of the unlock bit
  always @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      {wp, lk, wa, wd} <= 18'h0;
    end else begin
      wp <= HSEL && HREADYOUT && HTRANS == 2'b10 && HWRITE;
      wa <= HADDR;
      if (wp) wd <= HWDATA[7:0];
      if (wp && wa == 8'h00) lk <= HWDATA[0];
    end
  end
  a_resp_okay: assert property (!HRESP) else $error("error response");
  a_zero_wait: assert property ($past(RST_B, 4) |-> HREADYOUT) else $error("wait state");
  a_pin_pair: assert property (CRYSTAL_INPUT_SEL == XTAL_OSC_EN && CRYSTAL_OUTPUT_SEL == XTAL_OSC_EN)
    else $error("crystal pins split");
  a_cpu_sub: assert property (CPU_CLK_EN |-> SYS_CLK_EN) else $error("cpu enable alone");
  a_timer_gate: assert property (TIMER_CLK_EN |-> SYS_CLK_EN && TIMER_ACTIVE)
    else $error("timer enable in standby");
  a_ext_set: assert property (wp && wa == 8'h08 && lk |-> ##2 XTAL_OSC_EN == (wd[1:0] == 2'b11))
    else $error("crystal enable not written");
  a_lock_hold: assert property (wp && wa == 8'h08 && !lk |-> ##1 $stable(XTAL_OSC_EN) [*3])
    else $error("locked write took effect");
  a_osc_set: assert property (wp && wa == 8'h04 && lk |-> ##2 LOW_OSC_RUN == !wd[1])
    else $error("osc stop not written");
  a_stby_set: assert property (wp && wa == 8'h18 |-> ##2 TIMER_ACTIVE == !wd[1])
    else $error("standby not written");
  c_unlocked: cover property (wp && wa == 8'h08 && lk);
  c_locked: cover property (wp && wa == 8'h08 && !lk);
  c_timer: cover property (CPU_CLK_EN && TIMER_CLK_EN);
endmodule // scd_clock_ctrl_checker
bind scd_clock_ctrl scd_clock_ctrl_checker u_chk (
  .CORE_CLK(CORE_CLK),
  .RST_B(RST_B),
  .HSEL(HSEL),
  .HWRITE(HWRITE),
  .HREADYOUT(HREADYOUT),
  .HRESP(HRESP),
  .HADDR(HADDR),
  .HTRANS(HTRANS),
  .HWDATA(HWDATA),
  .LOW_OSC_RUN(LOW_OSC_RUN),
  .XTAL_OSC_EN(XTAL_OSC_EN),
  .CRYSTAL_INPUT_SEL(CRYSTAL_INPUT_SEL),
  .CRYSTAL_OUTPUT_SEL(CRYSTAL_OUTPUT_SEL),
  .SYS_CLK_EN(SYS_CLK_EN),
  .CPU_CLK_EN(CPU_CLK_EN),
  .TIMER_CLK_EN(TIMER_CLK_EN),
  .TIMER_ACTIVE(TIMER_ACTIVE)
);

// ===== testbench/scd_clock_ctrl_bench.sv
`timescale 1ns/1ps
module scd_clock_ctrl_bench;
  logic CORE_CLK = 1'b0;
  logic RST_B, HSEL, HWRITE, HS_OSC_TICK, XTAL_TICK, HREADYOUT, HRESP, LOW_OSC_RUN, XTAL_OSC_EN;
  logic CRYSTAL_INPUT_SEL, CRYSTAL_OUTPUT_SEL, SYS_CLK_EN, CPU_CLK_EN, TIMER_CLK_EN, TIMER_ACTIVE, rd_ph, cnt_on;
  logic [7:0] HADDR;
  logic [1:0] HTRANS;
  logic [2:0] HSIZE;
  logic [31:0] HWDATA, HRDATA;
  logic [31:0] exp_q[$];
  logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h02};
  wire HREADY = HREADYOUT;
  int fail_count, total_checks, sc, cc, tc, tk, n, i;
  scd_clock_ctrl DUT (
    .CORE_CLK(CORE_CLK),
    .RST_B(RST_B),
    .HSEL(HSEL),
    .HADDR(HADDR),
    .HTRANS(HTRANS),
    .HWRITE(HWRITE),
    .HSIZE(HSIZE),
    .HWDATA(HWDATA),
    .HREADY(HREADY),
    .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT),
    .HRESP(HRESP),
    .HS_OSC_TICK(HS_OSC_TICK),
    .XTAL_TICK(XTAL_TICK),
    .LOW_OSC_RUN(LOW_OSC_RUN),
    .XTAL_OSC_EN(XTAL_OSC_EN),
    .CRYSTAL_INPUT_SEL(CRYSTAL_INPUT_SEL),
    .CRYSTAL_OUTPUT_SEL(CRYSTAL_OUTPUT_SEL),
    .SYS_CLK_EN(SYS_CLK_EN),
    .CPU_CLK_EN(CPU_CLK_EN),
    .TIMER_CLK_EN(TIMER_CLK_EN),
    .TIMER_ACTIVE(TIMER_ACTIVE)
  );
  always #5 CORE_CLK = ~CORE_CLK;
  // Crystal period 6 cycles, on-chip 8, so the chosen source shows in the rate
  always @(posedge CORE_CLK) begin
    tk <= tk + 1;
    XTAL_TICK <= (tk % 6) < 3;
    HS_OSC_TICK <= (tk % 8) < 4;
  end
  // Read data judged in its data phase against the oldest note
  always @(posedge CORE_CLK) begin
    if (rd_ph) check(HRDATA, exp_q.pop_front());
    rd_ph <= HSEL && HTRANS == 2'b10 && !HWRITE && HREADYOUT === 1'b1;
  end
  // Pulse counters, sampled mid-cycle where outputs are settled; cleared while idle
  always @(negedge CORE_CLK) begin
    if (cnt_on) begin
      sc += SYS_CLK_EN === 1'b1;
      cc += CPU_CLK_EN === 1'b1;
      tc += TIMER_CLK_EN === 1'b1;
    end else begin
      {sc, cc, tc} = 0;
    end
  end
  task check(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR at %0t: saw %h, expected %h", $time, s, e);
    end
  endtask
  task complete_run;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Bounded wait for the ready edge; a hang ends the run
  task rdy;
    int k;
    k = 0;
    do begin
      @(posedge CORE_CLK);
      k++;
    end while (HREADYOUT !== 1'b1 && k < 50);
    if (HREADYOUT !== 1'b1) begin
      fail_count++;
      complete_run;
    end
  endtask
  task xfer(input bit w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CORE_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'b10;
    HADDR <= a;
    HWRITE <= w;
    rdy;
    HTRANS <= 2'b00;
    HWDATA <= d;
    rdy;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(0, a, 32'h0);
  endtask
  // Settle the enable pipeline, then count over a fixed window
  task meas(input int cyc);
    repeat (8) @(posedge CORE_CLK);
    cnt_on = 1;
    repeat (cyc) @(posedge CORE_CLK);
    cnt_on = 0;
  endtask
  initial begin
    void'($urandom(32'hE2879049));
    {RST_B, HSEL, HWRITE, HTRANS, HADDR, HWDATA, cnt_on} = 0;
    HSIZE = 3'h2;
    repeat (2) @(posedge CORE_CLK);
    RST_B <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    for (i = 0; i < 7; i++) rd(8'(4 * i), {24'h0, rv[i]});
    rd(8'h1C, 32'h2);
    rd(8'h24, 32'h0);
    meas(240);
    check(sc, 0);
    $display("reset test done");
    xfer(1, 8'h08, $urandom | 32'h3);
    xfer(1, 8'h04, 32'h2);
    rd(8'h08, 32'h0);
    check(LOW_OSC_RUN, 1);
    $display("lock test done");
    n = $urandom % 4;
    xfer(1, 8'h00, 32'h1);
    xfer(1, 8'h04, 32'h2);
    rd(8'h04, 32'h2);
    check(LOW_OSC_RUN, 0);
    xfer(1, 8'h04, 32'h0);
    xfer(1, 8'h08, 32'h3);
    repeat (20) @(posedge CORE_CLK);
    check({XTAL_OSC_EN, CRYSTAL_INPUT_SEL, CRYSTAL_OUTPUT_SEL}, 3'b111);
    rd(8'h1C, 32'h7);
    xfer(1, 8'h0C, 32'h0);
    xfer(1, 8'h10, n);
    xfer(1, 8'h14, 32'h80);
    xfer(1, 8'h18, 32'h0);
    xfer(1, 8'h00, 32'h0);
    xfer(1, 8'h10, 32'hFF);
    rd(8'h10, n);
    check(LOW_OSC_RUN, 1);
    meas(240);
    check(32'(sc >= 40 / (n + 1) - 1 && sc <= 40 / (n + 1) + 1), 1);
    check(cc, sc);
    check(tc, sc);
    $display("clock test done");
    // On-chip source (period 8) with the CPU field at one: half the system rate
    xfer(1, 8'h00, 32'h1);
    xfer(1, 8'h0C, 32'h41);
    meas(240);
    check(32'(sc >= 30 / (n + 1) - 1 && sc <= 30 / (n + 1) + 1), 1);
    check(32'(cc >= sc / 2 - 1 && cc <= sc / 2 + 1), 1);
    xfer(1, 8'h00, 32'h0);
    $display("source test done");
    xfer(1, 8'h18, 32'h2);
    meas(120);
    check(tc, 0);
    check(TIMER_ACTIVE, 0);
    $display("standby test done");
    complete_run;
  end
endmodule // scd_clock_ctrl_bench
